// >>> dv/fps_flash_prog_erase_test.sv
`timescale 1ns/100ps
module fps_flash_prog_erase_test;
  import fps_pkg::*;
  localparam int PP = 300;
  localparam int SE = 200;
  logic         clk, rst_n, cs_n, sclk, qe, a4, psp, dsp, write_in_progress, write_enable_latch;
  logic [3:0]   ql;
  logic [4:0]   bp;
  logic [7:0]   pa, pd;
  logic [31:0]  fa;
  fps_mem_req_t req;
  fps_mem_req_t exp_q[$];
  logic [7:0]   d[$], nod[$];
  int           fails, checks_done, cyc, seed;
  logic [7:0]   pv[9] = '{8'hFF, 8'h8E, 8'h00, 8'hFE, 8'h21, 8'h5C, 8'hDC, 8'hFF, 8'hFF};
  logic [7:0]   eo[6] = '{OP_SECTOR, OP_SECTOR_A4, OP_BLK32, OP_BLK32_A4, OP_BLK64, OP_BLK64_A4};
  int           eb[6] = '{12, 12, 15, 15, 16, 16};

  fps_host_model host_u (.o_cs_n(cs_n), .o_sclk(sclk), .o_quad_line(ql));

  // Short self-timed counts keep the run brief.
  fps_flash_prog_erase #(.P_PROGRAM_CYCLES(PP), .P_SECTOR_ERASE_CYCLES(SE),
    .P_BLOCK_ERASE_CYCLES(SE)) dut_u (
    .i_clk(clk), .i_reset_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_quad_line(ql),
    .i_quad_enable(qe), .i_addr4_mode(a4), .i_block_protect(bp),
    .i_persistent_sector_protect(psp), .i_dynamic_sector_protect(dsp), .i_param_addr(pa),
    .o_write_in_progress(write_in_progress), .o_write_enable_latch(write_enable_latch), .o_frame_addr(fa),
    .o_mem_req(req), .o_param_data(pd));

  // Core clock, 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string s);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, s, g, e);
    end
  endtask

  // Erase requests carry a size, program requests carry data.
  task automatic cmp_req(input fps_mem_req_t g, input fps_mem_req_t e);
    checks_done++;
    if (g.write !== e.write || g.erase !== e.erase || g.addr !== e.addr ||
        (e.erase ? g.size !== e.size : g.data !== e.data)) begin
      fails++;
      $display("MISMATCH t=%0t array request got %h exp %h", $time, g, e);
    end
  endtask

  function automatic fps_mem_req_t mk(input logic w, input fps_erase_t s,
                                      input logic [31:0] a, input logic [7:0] v);
    mk = '0;
    mk.write = w;
    mk.erase = ~w;
    mk.size = s;
    mk.addr = a;
    mk.data = v;
  endfunction

  task automatic fill(input int n);
    d.delete();
    repeat (n) d.push_back(8'($random(seed)));
  endtask

  // Final image per page offset: the last byte to land on an offset wins.
  task automatic expect_prog(input logic [31:0] a);
    logic [7:0] img[256];
    bit         hit[256];
    logic [7:0] o;
    foreach (d[i]) begin
      o = a[7:0] + 8'(i);
      img[o] = d[i];
      hit[o] = 1'b1;
    end
    for (int k = 0; k < 256; k++) begin
      if (hit[k]) exp_q.push_back(mk(1'b1, ER_SECTOR, {a[31:8], 8'(k)}, img[k]));
    end
  endtask

  // A refused frame (mn of 0) must leave the busy flag low and the latch as it was.
  task automatic run(input logic [7:0] op, input logic [31:0] a, input int ab, input bit q,
                     input int lim, input bit we, input int mn, input logic [7:0] dq[$]);
    int n;
    if (we) begin
      host_u.frame(OP_WRITE_ENABLE, '0, 0, 0, 99, nod);
      repeat (10) @(negedge clk);
      cmp(write_enable_latch, 1'b1, "latch set");
    end
    host_u.frame(op, a, ab, q, lim, dq);
    repeat (10) @(negedge clk);
    cmp(write_in_progress, mn > 0, "busy start");
    cmp(write_enable_latch, we && mn == 0, "latch");
    if (mn > 0) cmp(fa, a, "frame address");
    n = 0;
    while (write_in_progress === 1'b1 && n < PP + 600) begin
      @(negedge clk);
      n++;
    end
    cmp(write_in_progress, 1'b0, "busy end");
    // About 70 cycles of busy have passed before polling starts, so mn - 50 remain.
    cmp(n + 80 >= mn, 1'b1, "busy length");
    if (mn > 0) cmp(n + 30 <= mn, 1'b1, "busy length max");
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Every array request must match the oldest expectation.
  always @(negedge clk) begin
    if (req.write === 1'b1 || req.erase === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("MISMATCH t=%0t unexpected array request", $time);
      end else begin
        cmp_req(req, exp_q.pop_front());
      end
    end
  end

  // A hang is cut short well above the expected length of the run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      $display("MISMATCH t=%0t timeout", $time);
      report_and_stop();
    end
  end

  // Main sequence.
  initial begin
    seed = 10;
    rst_n = 1'b0;
    {qe, a4, psp, dsp} = 4'h0;
    bp = 5'h00;
    pa = 8'hC0;
    repeat (8) @(negedge clk);
    cmp(write_in_progress, 1'b0, "reset busy");
    cmp(write_enable_latch, 1'b0, "reset latch");
    rst_n = 1'b1;
    for (int i = 0; i < 9; i++) begin
      pa = (i < 8) ? 8'(8'hC0 + i) : 8'h10;
      repeat (2) @(negedge clk);
      cmp(pd, pv[i], "parameter byte");
    end
    done("parameters");
    fill(1);
    run(OP_PROG, 32'h0000_0100, 3, 0, 999, 0, 0, d);
    fill(3);
    expect_prog(32'h0000_12FE);
    run(OP_PROG, 32'h0000_12FE, 3, 0, 999, 1, PP - 20, d);
    fill(1);
    run(OP_PROG, 32'h0000_0100, 3, 0, 36, 1, 0, d);
    a4 = 1'b1;
    fill(2);
    expect_prog(32'h01AB_CDFF);
    run(OP_PROG_A4, 32'h01AB_CDFF, 4, 0, 999, 1, PP - 20, d);
    a4 = 1'b0;
    done("program");
    run(OP_QPROG, 32'h0000_0200, 3, 1, 999, 1, 0, d);
    qe = 1'b1;
    fill(258);
    expect_prog(32'h0000_3400);
    run(OP_QPROG, 32'h0000_3400, 3, 1, 999, 1, PP - 20, d);
    fill(1);
    expect_prog(32'h0100_0080);
    run(OP_QPROG_A4, 32'h0100_0080, 4, 1, 999, 1, PP - 20, d);
    done("quad");
    foreach (eo[i]) begin
      exp_q.push_back(mk(1'b0, fps_erase_t'(2'(i / 2)),
        ((i % 2) ? 32'h01AB_CDEF : 32'h00AB_CDEF) & ~((32'h1 << eb[i]) - 32'h1), 8'h00));
      run(eo[i], (i % 2) ? 32'h01AB_CDEF : 32'h00AB_CDEF, 3 + i % 2, 0, 999, 1, SE - 20,
        nod);
    end
    // Four-byte address mode widens the plain sector erase as well.
    a4 = 1'b1;
    exp_q.push_back(mk(1'b0, ER_SECTOR, 32'h0123_4000, 8'h00));
    run(OP_SECTOR, 32'h0123_4567, 4, 0, 999, 1, SE - 20, nod);
    a4 = 1'b0;
    run(OP_SECTOR, 32'h00AB_CDEF, 3, 0, 28, 1, 0, nod);
    done("erase");
    bp = 5'h01;
    run(OP_PROG_A4, 32'h01FF_0010, 4, 0, 999, 1, 0, d);
    run(OP_QPROG_A4, 32'h01FF_0010, 4, 1, 999, 1, 0, d);
    run(OP_SECTOR_A4, 32'h01FF_1000, 4, 0, 999, 1, 0, nod);
    // A large count code covers the whole array, even the bottom block.
    bp = 5'h0B;
    run(OP_SECTOR, 32'h0000_1000, 3, 0, 999, 1, 0, nod);
    bp = 5'h00;
    psp = 1'b1;
    run(OP_PROG, 32'h0000_0500, 3, 0, 999, 1, 0, d);
    psp = 1'b0;
    dsp = 1'b1;
    run(OP_PROG, 32'h0000_0500, 3, 0, 999, 1, 0, d);
    dsp = 1'b0;
    done("protection");
    repeat (20) @(negedge clk);
    cmp(exp_q.size(), 0, "pending requests");
    report_and_stop();
  end
endmodule  // fps_flash_prog_erase_test

// >>> dv/fps_host_model.sv
`timescale 1ns/100ps
module fps_host_model (
  output logic       o_cs_n,
  output logic       o_sclk,
  output logic [3:0] o_quad_line
);
  localparam realtime HALF = 62.5ns;
  int sent;
  int lim;

  // The link idles deselected with its clock parked low.
  initial begin
    o_cs_n      = 1'b1;
    o_sclk      = 1'b0;
    o_quad_line = 4'h0;
  end

  // One clock unit; units past the limit are dropped to cut a frame short.
  task automatic unit(input logic [3:0] v);
    if (sent < lim) begin
      o_quad_line = v;
      #HALF o_sclk = 1'b1;
      #HALF o_sclk = 1'b0;
      sent++;
    end
  endtask

  // Idle lines carry the inverse so a stale level is never mistaken for data.
  task automatic bit1(input logic b);
    unit({~b, ~b, ~b, b});
  endtask

  // Opcode and address go MSB first on line 0, quad data high nibble first.
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input int ab,
                       input bit q, input int n, input logic [7:0] dq[$]);
    sent = 0;
    lim = n;
    o_cs_n = 1'b0;
    #HALF;
    for (int i = 7; i >= 0; i--) bit1(op[i]);
    for (int i = ab * 8 - 1; i >= 0; i--) bit1(a[i]);
    foreach (dq[k]) begin
      if (q) begin
        unit(dq[k][7:4]);
        unit(dq[k][3:0]);
      end else begin
        for (int i = 7; i >= 0; i--) bit1(dq[k][i]);
      end
    end
    #HALF o_cs_n = 1'b1;
    o_quad_line = ~o_quad_line;
    #(4 * HALF);
  endtask
endmodule  // fps_host_model

// >>> verilog/fps_flash_prog_erase.sv
// Functional notes
// - Bytes past page end wrap to page start.
// - Over 256 bytes: last 256 programmed.
// - Fewer bytes: only those bytes written.
// - Chip select rises on byte boundary only.
// - Valid program runs timed cycle, busy flag.
// - Status stays readable during busy cycle.
// - Write enable latch cleared before cycle ends.
// - Protected page program is rejected.
// - 12H, 34H, 21H always take 32-bit address.
// - Quad program needs quad enable set.
// - Quad program shares cycle and protection.
// - Sector erase names any address inside.
// - Erase chip select rises after address.
// - Valid erase runs timed cycle, busy flag.
// - Protected sector erase is not done; sector protect bits here block program only, block protect blocks both.
// - Erase type opcodes at parameter bytes.
// - Command support bits reported as fixed.
// - Block erase behaves like sector erase.
`timescale 1ns/100ps
module fps_flash_prog_erase
  import fps_pkg::*;
#(
  parameter int unsigned P_PROGRAM_CYCLES      = PROGRAM_CYCLES,
  parameter int unsigned P_SECTOR_ERASE_CYCLES = SECTOR_ERASE_CYCLES,
  parameter int unsigned P_BLOCK_ERASE_CYCLES  = BLOCK_ERASE_CYCLES
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_cs_n,
  input  wire logic         i_sclk,
  input  wire logic [3:0]   i_quad_line,
  input  wire logic         i_quad_enable,
  input  wire logic         i_addr4_mode,
  input  wire logic [4:0]   i_block_protect,
  input  wire logic         i_persistent_sector_protect,
  input  wire logic         i_dynamic_sector_protect,
  input  wire logic [7:0]   i_param_addr,
  output logic              o_write_in_progress,
  output logic              o_write_enable_latch,
  output logic [31:0]       o_frame_addr,
  output fps_mem_req_t      o_mem_req,
  output logic [7:0]        o_param_data
);

  typedef enum logic [1:0] {S_OP = 2'b00, S_ADDR = 2'b01, S_DATA = 2'b11, S_SKIP = 2'b10} fps_fst_t;
  typedef enum logic [1:0] {C_IDLE = 2'b00, C_PROG = 2'b01, C_WAIT = 2'b11} fps_cst_t;

  function automatic logic is_prog(input logic [7:0] op);
    return op == OP_PROG || op == OP_PROG_A4 || op == OP_QPROG || op == OP_QPROG_A4;
  endfunction

  function automatic logic is_quad(input logic [7:0] op);
    return op == OP_QPROG || op == OP_QPROG_A4;
  endfunction

  function automatic logic is_erase(input logic [7:0] op);
    return op == OP_SECTOR || op == OP_SECTOR_A4 || op == OP_BLK32 || op == OP_BLK32_A4
        || op == OP_BLK64 || op == OP_BLK64_A4;
  endfunction

  function automatic logic is_addr4(input logic [7:0] op);
    return op == OP_PROG_A4 || op == OP_QPROG_A4 || op == OP_SECTOR_A4
        || op == OP_BLK32_A4 || op == OP_BLK64_A4;
  endfunction

  function automatic fps_erase_t erase_kind(input logic [7:0] op);
    if (op == OP_BLK32 || op == OP_BLK32_A4) return ER_BLK32;
    if (op == OP_BLK64 || op == OP_BLK64_A4) return ER_BLK64;
    return ER_SECTOR;
  endfunction

  // Protected 64 KB blocks counted from the top, or from the bottom when bit 4 is set.
  function automatic logic bp_covers(input logic [4:0] bp, input logic [31:0] a);
    int span;
    int blk;
    span = 0;
    blk  = int'(a[ARRAY_BITS-1:BLK64_BITS]);
    // Counted in int so that codes above ten cannot wrap to an empty span.
    if (bp[3:0] != 4'h0) span = 1 << (bp[3:0] - 4'h1);
    if (span >= BLOCKS) return 1'b1;
    if (bp[4]) return blk < span;
    return blk >= BLOCKS - span;
  endfunction

  function automatic logic [7:0] param_byte(input logic [7:0] a);
    case (a)
      PRM_C0:  return PRM_C0_VAL;
      PRM_C1:  return PRM_C1_VAL;
      PRM_C2:  return PRM_C2_VAL;
      PRM_C3:  return PRM_C3_VAL;
      PRM_C4:  return PRM_C4_VAL;
      PRM_C5:  return PRM_C5_VAL;
      PRM_C6:  return PRM_C6_VAL;
      PRM_C7:  return PRM_C7_VAL;
      default: return PRM_NONE;
    endcase
  endfunction

  logic [5:0]   meta_q, sync_q, hist_q;
  logic         cs_n, sclk_rise, cs_rise, cs_fall;
  logic [3:0]   io;
  fps_fst_t     st_q, st_d;
  logic [7:0]   op_q, op_d, sh_q, sh_d, ptr_q, ptr_d, byte_v;
  logic [31:0]  addr_q, addr_d;
  logic [2:0]   bit_q, bit_d, left_q, left_d;
  logic         got_q, got_d, quad_q, quad_d, wel_q, wel_d, byte_end, buf_we;
  logic [255:0] valid_q, valid_d;
  logic [7:0]   page_mem [256];
  logic         launch_prog, launch_erase, frame_ok, prot_hit;
  fps_cst_t     cst_q, cst_d;
  logic [31:0]  timer_q, timer_d;
  logic [7:0]   idx_q, idx_d;
  logic [23:0]  page_q, page_d;
  logic         wip_q, wip_d;
  fps_mem_req_t req_q, req_d;
  logic [7:0]   prm_q;

  // Pins pass two flops; a third stage only feeds edge detection.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= 6'h3_0;
      sync_q <= 6'h3_0;
      hist_q <= 6'h3_0;
    end else begin
      meta_q <= {i_cs_n, i_sclk, i_quad_line};
      sync_q <= meta_q;
      hist_q <= sync_q;
    end
  end

  assign cs_n      = sync_q[5];
  assign io        = sync_q[3:0];
  assign sclk_rise = sync_q[4] & ~hist_q[4];
  assign cs_rise   = sync_q[5] & ~hist_q[5];
  assign cs_fall   = ~sync_q[5] & hist_q[5];
  assign byte_v    = quad_q ? {sh_q[3:0], io} : {sh_q[6:0], io[0]};
  assign byte_end  = bit_q == (quad_q ? BIT_QUAD : BIT_LAST);
  assign prot_hit  = bp_covers(i_block_protect, addr_q)
                   | (is_prog(op_q) & (i_persistent_sector_protect | i_dynamic_sector_protect));
  // A frame counts only if it ends on a byte edge with the right amount of payload.
  assign frame_ok  = st_q == S_DATA && bit_q == 3'd0 && (is_prog(op_q) ? got_q : !got_q);

  // Instruction framing: opcode, address bytes, data bytes into the page buffer.
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    sh_d = sh_q;
    addr_d = addr_q;
    bit_d = bit_q;
    left_d = left_q;
    got_d = got_q;
    quad_d = quad_q;
    ptr_d = ptr_q;
    valid_d = valid_q;
    wel_d = wel_q;
    buf_we = 1'b0;
    launch_prog = 1'b0;
    launch_erase = 1'b0;
    if (cs_fall) begin
      st_d = S_OP;
      bit_d = 3'd0;
      got_d = 1'b0;
      quad_d = 1'b0;
    end else if (sclk_rise && !cs_n && st_q != S_SKIP) begin
      sh_d = byte_v;
      bit_d = byte_end ? 3'd0 : bit_q + (quad_q ? BIT_QUAD : 3'd1);
      if (byte_end) begin
        case (st_q)
          S_OP: begin
            op_d = byte_v;
            addr_d = 32'h0000_0000;
            // Busy cycles refuse everything; quad program without quad enable too.
            if (wip_q) begin
              st_d = S_SKIP;
            end else if (is_prog(byte_v) || is_erase(byte_v)) begin
              st_d = (is_quad(byte_v) && !i_quad_enable) ? S_SKIP : S_ADDR;
              left_d = (is_addr4(byte_v) || i_addr4_mode) ? ADDR_BYTES4 : ADDR_BYTES3;
            end else if (byte_v == OP_WRITE_ENABLE || byte_v == OP_WRITE_DISABLE) begin
              st_d = S_DATA;
            end else begin
              st_d = S_SKIP;
            end
          end
          S_ADDR: begin
            addr_d = {addr_q[23:0], byte_v};
            left_d = left_q - 3'd1;
            if (left_q == 3'd1) begin
              st_d = S_DATA;
              ptr_d = byte_v; // Data starts at the addressed byte of the page.
              valid_d = '0;
              quad_d = is_quad(op_q);
            end
          end
          S_DATA: begin
            got_d = 1'b1;
            if (is_prog(op_q)) begin
              buf_we = 1'b1;
              valid_d[ptr_q] = 1'b1;
              ptr_d = ptr_q + 8'd1;
            end
          end
          default: st_d = S_SKIP;
        endcase
      end
    end
    // Chip select rising closes the frame; a misaligned end abandons it.
    if (cs_rise) begin
      st_d = S_SKIP;
      if (frame_ok) begin
        if (op_q == OP_WRITE_ENABLE) begin
          wel_d = 1'b1;
        end else if (op_q == OP_WRITE_DISABLE) begin
          wel_d = 1'b0;
        end else if (wel_q && !prot_hit) begin
          launch_prog = is_prog(op_q);
          launch_erase = is_erase(op_q);
          wel_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= S_SKIP;
      op_q <= 8'h00;
      sh_q <= 8'h00;
      addr_q <= 32'h0000_0000;
      bit_q <= 3'd0;
      left_q <= 3'd0;
      got_q <= 1'b0;
      quad_q <= 1'b0;
      ptr_q <= 8'h00;
      valid_q <= '0;
      wel_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      bit_q <= bit_d;
      left_q <= left_d;
      got_q <= got_d;
      quad_q <= quad_d;
      ptr_q <= ptr_d;
      valid_q <= valid_d;
      wel_q <= wel_d;
    end
  end

  // Page buffer; later bytes at the same offset overwrite earlier ones.
  always_ff @(posedge i_clk) begin
    if (buf_we) begin
      page_mem[ptr_q] <= byte_v;
    end
  end

  // Self-timed cycle: program walks the buffer, then waits out the remaining time; erase only waits.
  // The walk takes 256 cycles, so the program time must exceed that.
  always_comb begin
    cst_d = cst_q;
    timer_d = timer_q;
    idx_d = idx_q;
    page_d = page_q;
    wip_d = wip_q;
    req_d = '0;
    case (cst_q)
      C_IDLE: begin
        if (launch_prog) begin
          cst_d = C_PROG;
          idx_d = 8'h00;
          page_d = addr_q[31:PAGE_BITS];
          timer_d = P_PROGRAM_CYCLES - 1;
          wip_d = 1'b1;
        end else if (launch_erase) begin
          cst_d = C_WAIT;
          wip_d = 1'b1;
          req_d.erase = 1'b1;
          req_d.size = erase_kind(op_q);
          case (erase_kind(op_q))
            ER_BLK32: req_d.addr = {addr_q[31:BLK32_BITS], BLK32_BITS'(0)};
            ER_BLK64: req_d.addr = {addr_q[31:BLK64_BITS], BLK64_BITS'(0)};
            default:  req_d.addr = {addr_q[31:SECTOR_BITS], SECTOR_BITS'(0)};
          endcase
          timer_d = (erase_kind(op_q) == ER_SECTOR) ? P_SECTOR_ERASE_CYCLES - 1
                                                    : P_BLOCK_ERASE_CYCLES - 1;
        end
      end
      C_PROG: begin
        timer_d = timer_q - 32'd1;
        req_d.write = valid_q[idx_q];
        req_d.addr = {page_q, idx_q};
        req_d.data = page_mem[idx_q];
        idx_d = idx_q + 8'd1;
        if (idx_q == PAGE_LAST) cst_d = C_WAIT;
      end
      C_WAIT: begin
        if (timer_q == 32'd0) begin
          cst_d = C_IDLE;
          wip_d = 1'b0;
        end else begin
          timer_d = timer_q - 32'd1;
        end
      end
      default: cst_d = C_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cst_q <= C_IDLE;
      timer_q <= 32'h0000_0000;
      idx_q <= 8'h00;
      page_q <= 24'h00_0000;
      wip_q <= 1'b0;
      req_q <= '0;
      prm_q <= 8'h00;
    end else begin
      cst_q <= cst_d;
      timer_q <= timer_d;
      idx_q <= idx_d;
      page_q <= page_d;
      wip_q <= wip_d;
      req_q <= req_d;
      prm_q <= param_byte(i_param_addr);
    end
  end

  // Status bits are plain flop outputs, readable at any time.
  assign o_write_in_progress  = wip_q;
  assign o_write_enable_latch = wel_q;
  assign o_frame_addr         = addr_q;
  assign o_mem_req            = req_q;
  assign o_param_data         = prm_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  wel_needed_a: assert property ((launch_prog || launch_erase) |-> wel_q)
    else $error("Cycle launched without write enable latch.");
  byte_edge_a: assert property ((launch_prog || launch_erase) |-> bit_q == 3'd0)
    else $error("Cycle launched on a partial byte.");
  protect_block_a: assert property ((launch_prog || launch_erase) |-> !prot_hit)
    else $error("Cycle launched on a protected region.");
  quad_gate_a: assert property ($rose(quad_q) |-> $past(i_quad_enable, 2))
    else $error("Quad data accepted while quad enable was clear.");
  wip_start_a: assert property (launch_prog |=> (wip_q && !wel_q) [*3])
    else $error("Program did not raise busy and clear write enable.");
  erase_busy_a: assert property (launch_erase |=> req_q.erase ##1 wip_q [*4])
    else $error("Erase request or busy flag missing.");
  erase_align_a: assert property (req_q.erase |-> req_q.addr[SECTOR_BITS-1:0] == 12'h000)
    else $error("Erase address not sector aligned.");
  page_wrap_a: assert property (req_q.write |-> req_q.addr[31:PAGE_BITS] == page_q)
    else $error("Program byte left the addressed page.");
  param_type_a: assert property (i_param_addr == PRM_C4 |=> o_param_data == 8'h21)
    else $error("Erase type 1 opcode misreported.");
  busy_refuse_a: assert property (wip_q |-> !launch_prog && !launch_erase)
    else $error("Launch accepted during busy cycle.");

  prog_seen_c: cover property (launch_prog ##1 cst_q == C_PROG);
  quad_seen_c: cover property (launch_prog && is_quad(op_q));
  erase_seen_c: cover property (launch_erase && erase_kind(op_q) == ER_SECTOR);
  wrap_seen_c: cover property (buf_we && ptr_q == PAGE_LAST);

endmodule // fps_flash_prog_erase

// >>> verilog/fps_pkg.sv
package fps_pkg;
  // Core clock and self-timed cycle durations.
  localparam int CLK_PERIOD_NS          = 4;
  localparam int PROGRAM_TIME_NS        = 400_000;
  localparam int SECTOR_ERASE_TIME_NS   = 45_000_000;
  localparam int BLOCK_ERASE_TIME_NS    = 150_000_000;
  // Durations round up to whole clock cycles.
  localparam int PROGRAM_CYCLES      = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SECTOR_ERASE_CYCLES = (SECTOR_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLOCK_ERASE_CYCLES  = (BLOCK_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Instruction opcodes.
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_PROG          = 8'h02;
  localparam logic [7:0] OP_PROG_A4       = 8'h12;
  localparam logic [7:0] OP_QPROG         = 8'h32;
  localparam logic [7:0] OP_QPROG_A4      = 8'h34;
  localparam logic [7:0] OP_SECTOR        = 8'h20;
  localparam logic [7:0] OP_SECTOR_A4     = 8'h21;
  localparam logic [7:0] OP_BLK32         = 8'h52;
  localparam logic [7:0] OP_BLK32_A4      = 8'h5C;
  localparam logic [7:0] OP_BLK64         = 8'hD8;
  localparam logic [7:0] OP_BLK64_A4      = 8'hDC;

  // Address field geometry.
  localparam int          PAGE_BITS    = 8;
  localparam int          SECTOR_BITS  = 12;
  localparam int          BLK32_BITS   = 15;
  localparam int          BLK64_BITS   = 16;
  localparam int          ARRAY_BITS   = 25;
  localparam int          BLOCKS       = 512;
  localparam logic [2:0]  ADDR_BYTES3  = 3'd3;
  localparam logic [2:0]  ADDR_BYTES4  = 3'd4;
  localparam logic [2:0]  BIT_LAST     = 3'd7;
  localparam logic [2:0]  BIT_QUAD     = 3'd4;
  localparam logic [7:0]  PAGE_LAST    = 8'hFF;

  // Discoverable parameter bytes for command support and erase types.
  localparam logic [7:0] PRM_C0 = 8'hC0, PRM_C0_VAL = 8'hFF;
  localparam logic [7:0] PRM_C1 = 8'hC1, PRM_C1_VAL = 8'h8E;
  localparam logic [7:0] PRM_C2 = 8'hC2, PRM_C2_VAL = 8'h00;
  localparam logic [7:0] PRM_C3 = 8'hC3, PRM_C3_VAL = 8'hFE;
  localparam logic [7:0] PRM_C4 = 8'hC4, PRM_C4_VAL = 8'h21;
  localparam logic [7:0] PRM_C5 = 8'hC5, PRM_C5_VAL = 8'h5C;
  localparam logic [7:0] PRM_C6 = 8'hC6, PRM_C6_VAL = 8'hDC;
  localparam logic [7:0] PRM_C7 = 8'hC7, PRM_C7_VAL = 8'hFF;
  localparam logic [7:0] PRM_NONE = 8'hFF;

  typedef enum logic [1:0] {ER_SECTOR = 2'b00, ER_BLK32 = 2'b01, ER_BLK64 = 2'b10} fps_erase_t;

  // One array request: page byte write or region erase.
  typedef struct packed {
    logic        write;
    logic        erase;
    fps_erase_t  size;
    logic [31:0] addr;
    logic [7:0]  data;
  } fps_mem_req_t;
endpackage
